// ---- pkg/clk_mode_pkg.sv ----
// shared constants and types for the system clock and power mode block
package clk_mode_pkg;

    // ----------------------------------------
    // operating modes
    // ----------------------------------------
    typedef enum logic [2:0] {
        MODE_FAST = 3'h0,
        MODE_SLOW = 3'h1,
        MODE_SLEEP = 3'h2,
        MODE_IDLE_LOW_ONLY = 3'h3,
        MODE_IDLE_BOTH_OSC = 3'h4,
        MODE_IDLE_HIGH_ONLY = 3'h5
    } power_mode_t;

    // ----------------------------------------
    // selections, widths and reset values
    // ----------------------------------------
    localparam logic [2:0] SEL_SUB_CLOCK = 3'h7;
    localparam int HIGH_DIV_BITS = 6;
    localparam int TIMEBASE_DIV_BITS = 3;
    localparam int SYNC_STAGES = 2;
    localparam power_mode_t MODE_RESET = MODE_FAST;
    localparam logic CLOCK_OUT_RESET = 1'h0;
    localparam logic OSC_EN_RESET = 1'h0;
    localparam logic CPU_RUN_RESET = 1'h1;

endpackage

// ---- pkg/osc_tick_if.sv ----
// synchronised oscillator level and rising-edge tick passed between modules
`timescale 1ns/1ps
interface osc_tick_if;
    logic level;
    logic rise;

    modport src (output level, output rise);
    modport dst (input level, input rise);
endinterface

// ---- src/osc_sync.sv ----
// two-flop synchroniser with rising-edge tick for one raw oscillator wave
`timescale 1ns/1ps
module osc_sync
    import clk_mode_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic osc_in,
    osc_tick_if.src tick
);
    // ----------------------------------------
    // synchroniser
    // ----------------------------------------
    logic meta;
    logic stable;
    logic prev;

    // the first stage feeds only the second; edge logic looks at later stages
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'h0;
            stable <= 1'h0;
        end else begin
            meta <= osc_in;
            stable <= meta;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 1'h0;
        end else begin
            prev <= stable;
        end
    end

    assign tick.level = stable;
    assign tick.rise = stable & ~prev;
endmodule

// ---- src/tick_counter.sv ----
// free-running binary counter of source ticks; bit k is the source over 2^(k+1)
`timescale 1ns/1ps
module tick_counter
    import clk_mode_pkg::*;
#(
    parameter int WIDTH = HIGH_DIV_BITS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    osc_tick_if.dst tick,
    output logic [WIDTH-1:0] count
);
    // ----------------------------------------
    // counter
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (tick.rise) begin
            count <= count + WIDTH'(1);
        end
    end
endmodule

// ---- src/clk_power_ctrl.sv ----
// system clock source selection and low-power mode control, top level
//
// Contract
// RULE1: select 000-110 fast mode, 111 slow mode
// RULE2: encodings give high clock over 1..64, sub
// RULE3: high clock from fast crystal, fast or mid rc
// RULE4: high select 0 picks rc group, 1 crystal
// RULE5: sub clock from slow crystal or slow rc
// RULE6: low select 0 slow rc, 1 slow crystal
// RULE7: fast mode divides high source by 1..64
// RULE8: after move to sub, enable bit keeps high
// RULE9: slow mode high clock follows enable bit only
// RULE10: halt with both keeps 0 enters sleep
// RULE11: sleep timebase runs if enabled, slow over 8
// RULE12: halt low keep only enters idle_low_only
// RULE13: halt both keeps enters idle_both_osc
// RULE14: halt high keep only enters idle_high_only
// RULE15: crystal used only when on, stable, selected
// RULE16: software selects crystal only after stable
// RULE17: slow crystal follows its own enable only
// RULE18: sleep/idle_high_only slow rc on when consumers on
// RULE19: lcd clocks off unless lcd on, same source
// RULE20: keep bits sampled when halt executes
`timescale 1ns/1ps
module clk_power_ctrl
    import clk_mode_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    // cpu side
    input wire logic halt_req,
    input wire logic wake_req,
    output logic cpu_run,
    output power_mode_t power_mode,
    // configuration bits
    input wire logic [2:0] sys_clk_select,
    input wire logic high_osc_select,
    input wire logic low_osc_select,
    input wire logic [2:0] rc_freq_select,
    input wire logic high_osc_idle_keep,
    input wire logic low_osc_idle_keep,
    input wire logic fast_crystal_on,
    input wire logic rc_osc_on,
    input wire logic crystal32k_on,
    input wire logic lcd_on,
    input wire logic timebase_on,
    input wire logic watchdog_on,
    // oscillator side
    input wire logic crystal32k_stable,
    input wire logic fast_crystal_osc,
    input wire logic fast_rc_osc,
    input wire logic mid_rc_osc,
    input wire logic slow_rc_osc,
    input wire logic slow_crystal_osc,
    output logic fast_crystal_en,
    output logic fast_rc_en,
    output logic mid_rc_en,
    output logic slow_rc_en,
    output logic slow_crystal_en,
    // derived clocks
    output logic system_clock,
    output logic high_clock,
    output logic sub_clock,
    output logic timebase_clock,
    output logic lcd_clock,
    output logic lcd_pump_clock
);
    // ----------------------------------------
    // oscillator synchronisers
    // ----------------------------------------
    osc_tick_if fxt_if ();
    osc_tick_if frc_if ();
    osc_tick_if mrc_if ();
    osc_tick_if src_if ();
    osc_tick_if sxt_if ();
    osc_tick_if high_if ();
    osc_tick_if slow_if ();

    osc_sync u_sync_fxt (.core_clk(core_clk), .rst_n(rst_n), .osc_in(fast_crystal_osc),
        .tick(fxt_if));
    osc_sync u_sync_frc (.core_clk(core_clk), .rst_n(rst_n), .osc_in(fast_rc_osc),
        .tick(frc_if));
    osc_sync u_sync_mrc (.core_clk(core_clk), .rst_n(rst_n), .osc_in(mid_rc_osc),
        .tick(mrc_if));
    osc_sync u_sync_src (.core_clk(core_clk), .rst_n(rst_n), .osc_in(slow_rc_osc),
        .tick(src_if));
    osc_sync u_sync_sxt (.core_clk(core_clk), .rst_n(rst_n), .osc_in(slow_crystal_osc),
        .tick(sxt_if));

    // crystal stable flag comes from the analog side
    logic stable_meta;
    logic stable_sync;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stable_meta <= 1'h0;
            stable_sync <= 1'h0;
        end else begin
            stable_meta <= crystal32k_stable;
            stable_sync <= stable_meta;
        end
    end

    // ----------------------------------------
    // source selection
    // ----------------------------------------
    logic use_crystal;
    logic use_mid_rc;

    // crystal only once it is on, stable and selected; otherwise slow rc
    assign use_crystal = crystal32k_on & stable_sync & low_osc_select; // RULE15 RULE6
    // software is trusted to raise low_osc_select only after stable; the
    // stable term above keeps the rc in charge if it does not
    // RULE16
    assign use_mid_rc = rc_freq_select[2];

    always_comb begin
        if (high_osc_select) begin // RULE4
            high_if.level = fxt_if.level;
            high_if.rise = fxt_if.rise;
        end else if (use_mid_rc) begin // RULE3
            high_if.level = mrc_if.level;
            high_if.rise = mrc_if.rise;
        end else begin
            high_if.level = frc_if.level;
            high_if.rise = frc_if.rise;
        end
    end

    always_comb begin
        if (use_crystal) begin // RULE5
            slow_if.level = sxt_if.level;
            slow_if.rise = sxt_if.rise;
        end else begin
            slow_if.level = src_if.level;
            slow_if.rise = src_if.rise;
        end
    end

    // ----------------------------------------
    // dividers
    // ----------------------------------------
    logic [HIGH_DIV_BITS-1:0] high_count;
    logic [TIMEBASE_DIV_BITS-1:0] slow_count;

    tick_counter #(.WIDTH(HIGH_DIV_BITS)) u_high_div (.core_clk(core_clk), .rst_n(rst_n),
        .tick(high_if), .count(high_count));
    tick_counter #(.WIDTH(TIMEBASE_DIV_BITS)) u_slow_div (.core_clk(core_clk),
        .rst_n(rst_n), .tick(slow_if), .count(slow_count));

    logic divided_high;

    // bit k of the tick counter toggles at the source over 2^(k+1)
    always_comb begin
        unique case (sys_clk_select)
            3'h0: divided_high = high_if.level; // RULE2 RULE7
            3'h1: divided_high = high_count[0];
            3'h2: divided_high = high_count[1];
            3'h3: divided_high = high_count[2];
            3'h4: divided_high = high_count[3];
            3'h5: divided_high = high_count[4];
            3'h6: divided_high = high_count[5];
            3'h7: divided_high = slow_if.level;
        endcase
    end

    // ----------------------------------------
    // mode state machine
    // ----------------------------------------
    logic sub_selected;
    power_mode_t run_mode;
    power_mode_t halt_mode;
    power_mode_t next_power_mode;

    assign sub_selected = (sys_clk_select == SEL_SUB_CLOCK);
    assign run_mode = sub_selected ? MODE_SLOW : MODE_FAST; // RULE1

    // keep bits are read in the halt cycle itself, later changes do not move the mode
    always_comb begin
        unique case ({high_osc_idle_keep, low_osc_idle_keep}) // RULE20
            2'h0: halt_mode = MODE_SLEEP; // RULE10
            2'h1: halt_mode = MODE_IDLE_LOW_ONLY; // RULE12
            2'h3: halt_mode = MODE_IDLE_BOTH_OSC; // RULE13
            2'h2: halt_mode = MODE_IDLE_HIGH_ONLY; // RULE14
        endcase
    end

    always_comb begin
        unique case (power_mode)
            MODE_FAST, MODE_SLOW: begin
                next_power_mode = halt_req ? halt_mode : run_mode;
            end
            MODE_SLEEP, MODE_IDLE_LOW_ONLY, MODE_IDLE_BOTH_OSC, MODE_IDLE_HIGH_ONLY: begin
                next_power_mode = wake_req ? run_mode : power_mode;
            end
            default: begin
                next_power_mode = run_mode;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_mode <= MODE_RESET;
        end else begin
            power_mode <= next_power_mode;
        end
    end

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    logic in_run;
    logic in_slow;
    logic high_kept;
    logic sub_kept;
    logic deep_low;
    logic selected_high_on;
    logic high_on;
    logic sys_on;
    logic slow_consumers;

    assign in_run = (next_power_mode == MODE_FAST) || (next_power_mode == MODE_SLOW);
    assign in_slow = (next_power_mode == MODE_SLOW);
    assign high_kept = (next_power_mode == MODE_FAST) ||
        (next_power_mode == MODE_IDLE_BOTH_OSC) || (next_power_mode == MODE_IDLE_HIGH_ONLY);
    assign sub_kept = in_run || (next_power_mode == MODE_IDLE_LOW_ONLY) ||
        (next_power_mode == MODE_IDLE_BOTH_OSC);
    assign deep_low = (next_power_mode == MODE_SLEEP) ||
        (next_power_mode == MODE_IDLE_HIGH_ONLY);
    assign selected_high_on = high_osc_select ? fast_crystal_on : rc_osc_on;
    assign slow_consumers = timebase_on | watchdog_on | lcd_on;

    // in slow mode the selected high oscillator lives only by its own enable bit
    assign high_on = high_kept || (in_slow && selected_high_on); // RULE8 RULE9

    always_comb begin
        unique case (next_power_mode)
            MODE_FAST, MODE_SLOW, MODE_IDLE_BOTH_OSC: sys_on = 1'h1; // RULE13
            MODE_IDLE_LOW_ONLY: sys_on = sub_selected; // RULE12
            MODE_IDLE_HIGH_ONLY: sys_on = !sub_selected; // RULE14
            MODE_SLEEP: sys_on = 1'h0; // RULE10
            default: sys_on = 1'h0;
        endcase
    end

    // ----------------------------------------
    // oscillator enables
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_crystal_en <= OSC_EN_RESET;
            fast_rc_en <= OSC_EN_RESET;
            mid_rc_en <= OSC_EN_RESET;
        end else begin
            // an unselected high oscillator still follows its enable bit while awake
            fast_crystal_en <= (high_on && high_osc_select) ||
                (in_run && fast_crystal_on); // RULE8 RULE9
            fast_rc_en <= (high_on && !high_osc_select && !use_mid_rc) ||
                (in_run && rc_osc_on && !use_mid_rc);
            mid_rc_en <= (high_on && !high_osc_select && use_mid_rc) ||
                (in_run && rc_osc_on && use_mid_rc);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_crystal_en <= OSC_EN_RESET;
            slow_rc_en <= OSC_EN_RESET;
        end else begin
            slow_crystal_en <= crystal32k_on; // RULE17
            if (use_crystal) begin
                slow_rc_en <= 1'h0; // RULE15
            end else if (deep_low) begin
                slow_rc_en <= slow_consumers; // RULE18
            end else begin
                slow_rc_en <= 1'h1; // RULE17
            end
        end
    end

    // ----------------------------------------
    // clock outputs
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_run <= CPU_RUN_RESET;
            system_clock <= CLOCK_OUT_RESET;
            high_clock <= CLOCK_OUT_RESET;
            sub_clock <= CLOCK_OUT_RESET;
        end else begin
            cpu_run <= in_run; // RULE10
            system_clock <= sys_on && divided_high; // RULE1
            high_clock <= high_on && high_if.level; // RULE3
            sub_clock <= sub_kept && slow_if.level; // RULE5
        end
    end

    // timebase stays alive in every mode, sleep included, while its users are on
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timebase_clock <= CLOCK_OUT_RESET;
        end else begin
            timebase_clock <= (timebase_on || watchdog_on) &&
                slow_count[TIMEBASE_DIV_BITS-1]; // RULE11
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lcd_clock <= CLOCK_OUT_RESET;
            lcd_pump_clock <= CLOCK_OUT_RESET;
        end else begin
            lcd_clock <= lcd_on && slow_if.level; // RULE19
            lcd_pump_clock <= lcd_on && slow_if.level; // RULE19
        end
    end
endmodule

// ---- tb/clk_power_ctrl_assertions.sv ----
// concurrent checks on the ports of the clock and power mode block
`timescale 1ns/1ps
module clk_power_ctrl_assertions
    import clk_mode_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic halt_req,
    input wire logic cpu_run,
    input wire power_mode_t power_mode,
    input wire logic [2:0] sys_clk_select,
    input wire logic low_osc_select,
    input wire logic high_osc_idle_keep,
    input wire logic low_osc_idle_keep,
    input wire logic crystal32k_on,
    input wire logic lcd_on,
    input wire logic timebase_on,
    input wire logic watchdog_on,
    input wire logic slow_rc_en,
    input wire logic slow_crystal_en,
    input wire logic system_clock,
    input wire logic high_clock,
    input wire logic sub_clock,
    input wire logic timebase_clock,
    input wire logic lcd_clock,
    input wire logic lcd_pump_clock
);
    // ----------------------------------------
    // halt entry
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_halt(h, l);
        halt_req && cpu_run && high_osc_idle_keep == h && low_osc_idle_keep == l;
    endsequence
    property p_sleep_entry;
        s_halt(0, 0) |=> power_mode == MODE_SLEEP && !cpu_run;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("no sleep on halt");
    property p_idle_low_entry;
        s_halt(0, 1) |=> power_mode == MODE_IDLE_LOW_ONLY && !cpu_run;
    endproperty
    a_idle_low_entry: assert property (p_idle_low_entry) else $error("no idle low");
    property p_idle_both_entry;
        s_halt(1, 1) |=> power_mode == MODE_IDLE_BOTH_OSC && !cpu_run;
    endproperty
    a_idle_both_entry: assert property (p_idle_both_entry) else $error("no idle both");
    property p_idle_high_entry;
        s_halt(1, 0) |=> power_mode == MODE_IDLE_HIGH_ONLY && !cpu_run;
    endproperty
    a_idle_high_entry: assert property (p_idle_high_entry) else $error("no idle high");
    // ----------------------------------------
    // modes and clocks
    // ----------------------------------------
    property p_cpu_run;
        cpu_run == (power_mode inside {MODE_FAST, MODE_SLOW});
    endproperty
    a_cpu_run: assert property (p_cpu_run) else $error("cpu run disagrees with mode");
    property p_slow_mode;
        (cpu_run && !halt_req && sys_clk_select == SEL_SUB_CLOCK) [*2] |-> power_mode == MODE_SLOW;
    endproperty
    a_slow_mode: assert property (p_slow_mode) else $error("select 7 not slow");
    property p_sleep_clocks;
        (power_mode == MODE_SLEEP) [*3] |-> !system_clock && !high_clock && !sub_clock;
    endproperty
    a_sleep_clocks: assert property (p_sleep_clocks) else $error("clock runs in sleep");
    property p_idle_high_clk;
        (power_mode == MODE_IDLE_HIGH_ONLY) [*3] |-> !sub_clock;
    endproperty
    a_idle_high_clk: assert property (p_idle_high_clk) else $error("sub clock in idle");
    property p_xtal_en;
        $stable(crystal32k_on) [*2] |-> slow_crystal_en == crystal32k_on;
    endproperty
    a_xtal_en: assert property (p_xtal_en) else $error("crystal enable wrong");
    property p_lcd_off;
        (!lcd_on) [*3] |-> !lcd_clock && !lcd_pump_clock;
    endproperty
    a_lcd_off: assert property (p_lcd_off) else $error("lcd clock while off");
    property p_tb_off;
        (!timebase_on && !watchdog_on) [*3] |-> !timebase_clock;
    endproperty
    a_tb_off: assert property (p_tb_off) else $error("timebase clock while off");
    // slow rc serves only its consumers in sleep and idle_high_only while the rc is the low source
    property p_rc_consumers;
        (power_mode inside {MODE_SLEEP, MODE_IDLE_HIGH_ONLY} && !low_osc_select) [*2]
            |-> slow_rc_en == $past(timebase_on || watchdog_on || lcd_on);
    endproperty
    a_rc_consumers: assert property (p_rc_consumers) else $error("slow rc enable wrong");
endmodule
bind clk_power_ctrl clk_power_ctrl_assertions i_clk_power_ctrl_assertions (.core_clk, .rst_n,
    .halt_req, .cpu_run, .power_mode, .sys_clk_select, .low_osc_select, .high_osc_idle_keep,
    .low_osc_idle_keep, .crystal32k_on, .lcd_on, .timebase_on, .watchdog_on, .slow_rc_en,
    .slow_crystal_en, .system_clock, .high_clock, .sub_clock, .timebase_clock, .lcd_clock,
    .lcd_pump_clock);

// ---- tb/osc_model.sv ----
// behavioural oscillators and slow crystal lock flag facing the block
`timescale 1ns/1ps
module osc_model (
    input wire logic fast_crystal_en,
    input wire logic fast_rc_en,
    input wire logic mid_rc_en,
    input wire logic slow_rc_en,
    input wire logic slow_crystal_en,
    output logic fast_crystal_osc = 1'h0,
    output logic fast_rc_osc = 1'h0,
    output logic mid_rc_osc = 1'h0,
    output logic slow_rc_osc = 1'h0,
    output logic slow_crystal_osc = 1'h0,
    output logic crystal32k_stable = 1'h0
);
    int lock = 0;
    // a stopped oscillator holds its level; odd halves keep edges off the core clock
    always #10.1 if (fast_crystal_en) fast_crystal_osc = ~fast_crystal_osc;
    always #12.1 if (fast_rc_en) fast_rc_osc = ~fast_rc_osc;
    always #40.1 if (mid_rc_en) mid_rc_osc = ~mid_rc_osc;
    always #100.1 if (slow_rc_en) slow_rc_osc = ~slow_rc_osc;
    always #130.1 if (slow_crystal_en) slow_crystal_osc = ~slow_crystal_osc;
    // lock flag rises 2 us after enable, drops at once on disable
    always #50 begin
        lock = slow_crystal_en ? (lock < 40 ? lock + 1 : 40) : 0;
        crystal32k_stable = lock == 40;
    end
endmodule

// ---- tb/tb_clk_power_ctrl.sv ----
// self-checking bench for the clock and power mode block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((e) !== (g)) begin errors++; \
    $display("BAD %s expected %0h seen %0h", n, e, g); end end
module tb_clk_power_ctrl
    import clk_mode_pkg::*;
;
    logic core_clk = 0, rst_n = 0, halt_req = 0, wake_req = 0, rc_osc_on = 0;
    logic high_osc_select = 1, low_osc_select = 0, high_osc_idle_keep = 0;
    logic low_osc_idle_keep = 0, fast_crystal_on = 0, crystal32k_on = 0, lcd_on = 0;
    logic timebase_on = 0, watchdog_on = 0;
    logic [2:0] sys_clk_select = 3'h0, rc_freq_select = 3'h0;
    logic cpu_run, crystal32k_stable, fast_crystal_osc, fast_rc_osc, mid_rc_osc;
    logic slow_rc_osc, slow_crystal_osc, fast_crystal_en, fast_rc_en, mid_rc_en;
    logic slow_rc_en, slow_crystal_en, system_clock, high_clock, sub_clock;
    logic timebase_clock, lcd_clock, lcd_pump_clock;
    logic [5:0] clks, last;
    logic [31:0] seed = 32'h0000117b, r;
    power_mode_t power_mode;
    int tg[6];
    int errors = 0, comparisons = 0, cyc = 0;
    real per;

    clk_power_ctrl i_clk_power_ctrl (.core_clk, .rst_n, .halt_req, .wake_req, .cpu_run,
        .power_mode, .sys_clk_select, .high_osc_select, .low_osc_select, .rc_freq_select,
        .high_osc_idle_keep, .low_osc_idle_keep, .fast_crystal_on, .rc_osc_on, .crystal32k_on,
        .lcd_on, .timebase_on, .watchdog_on, .crystal32k_stable, .fast_crystal_osc,
        .fast_rc_osc, .mid_rc_osc, .slow_rc_osc, .slow_crystal_osc, .fast_crystal_en,
        .fast_rc_en, .mid_rc_en, .slow_rc_en, .slow_crystal_en, .system_clock, .high_clock,
        .sub_clock, .timebase_clock, .lcd_clock, .lcd_pump_clock);
    osc_model i_osc_model (.fast_crystal_en, .fast_rc_en, .mid_rc_en, .slow_rc_en,
        .slow_crystal_en, .fast_crystal_osc, .fast_rc_osc, .mid_rc_osc, .slow_rc_osc,
        .slow_crystal_osc, .crystal32k_stable);

    // ----------------------------------------
    // clock, toggle counters, timeout
    // ----------------------------------------
    always #2 core_clk = ~core_clk;
    assign clks = {lcd_pump_clock, lcd_clock, timebase_clock, sub_clock, high_clock, system_clock};
    always @(posedge core_clk) begin
        for (int k = 0; k < 6; k++) tg[k] += (clks[k] !== last[k]);
        last <= clks;
        cyc++;
        if (cyc == 40000) begin
            errors++;
            print_verdict();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // counts near phase boundaries may slip by a toggle or two
    function automatic logic near(int e, int g);
        return g >= e - 2 && g <= e + 2;
    endfunction
    function automatic power_mode_t exp_mode(logic h, logic l);
        return h ? (l ? MODE_IDLE_BOTH_OSC : MODE_IDLE_HIGH_ONLY)
                 : (l ? MODE_IDLE_LOW_ONLY : MODE_SLEEP);
    endfunction
    // {system, high, sub} running while halted
    function automatic logic [2:0] exp_on(logic h, logic l, logic [2:0] s);
        case ({h, l})
            2'h0: return 3'h0;
            2'h1: return {s == SEL_SUB_CLOCK, 2'h1};
            2'h3: return 3'h7;
            default: return {s != SEL_SUB_CLOCK, 2'h2};
        endcase
    endfunction
    task window(int n);
        repeat (4) @(negedge core_clk);
        foreach (tg[k]) tg[k] = 0;
        repeat (n) @(negedge core_clk);
    endtask
    task print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(negedge core_clk);
        `CHK("reset mode", MODE_RESET, power_mode)
        `CHK("reset outs", 11'h000, {fast_crystal_en, fast_rc_en, mid_rc_en, slow_rc_en,
            slow_crystal_en, clks})
        rst_n = 1;
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            sys_clk_select = i[2] ? SEL_SUB_CLOCK : 3'(r % 7);
            {timebase_on, watchdog_on, lcd_on} = r[6:4];
            {high_osc_idle_keep, low_osc_idle_keep} = 2'(i);
            window(10);
            halt_req = 1;
            @(negedge core_clk) halt_req = 0;
            `CHK("halt mode", exp_mode(i[1], i[0]), power_mode)
            `CHK("halt run", 1'b0, cpu_run)
            // a second halt with other keep bits must leave the mode alone
            {high_osc_idle_keep, low_osc_idle_keep} = ~2'(i);
            @(negedge core_clk) halt_req = 1;
            @(negedge core_clk) halt_req = 0;
            `CHK("halt again", exp_mode(i[1], i[0]), power_mode)
            window(400);
            `CHK("halt clocks", exp_on(i[1], i[0], sys_clk_select),
                {tg[0] != 0, tg[1] != 0, tg[2] != 0})
            `CHK("halt rc", i[0] ? 1'b1 : |r[6:4], slow_rc_en)
            wake_req = 1;
            @(negedge core_clk) wake_req = 0;
            `CHK("wake mode", i[2] ? MODE_SLOW : MODE_FAST, power_mode)
            $display("halt test %0d done", i);
        end
        for (int i = 0; i < 7; i++) begin
            per = i % 3 == 0 ? 20.2 : (i % 3 == 1 ? 24.2 : 80.2);
            high_osc_select = i % 3 == 0;
            rc_freq_select = {i % 3 == 2, 2'(rnd())};
            sys_clk_select = 3'(i);
            window(640);
            `CHK("divider", 1'b1, near(int'(5120.0 / per) >> i, tg[0]))
            `CHK("high src", 1'b1, near(int'(5120.0 / per), tg[1]))
            `CHK("high en", {i % 3 == 0, i % 3 == 1, i % 3 == 2},
                {fast_crystal_en, fast_rc_en, mid_rc_en})
        end
        $display("divider test done");
        timebase_on = 1;
        for (int j = 0; j < 4; j++) begin
            r = rnd();
            lcd_on = r[0];
            crystal32k_on = j[1];
            for (int w = 0; w < 2000 && j == 3 && !crystal32k_stable; w++)
                @(negedge core_clk);
            low_osc_select = j[0];
            per = j == 3 ? 260.2 : 200.2;
            window(2600);
            `CHK("slow rc en", j != 3, slow_rc_en)
            `CHK("xtal en", j[1], slow_crystal_en)
            `CHK("sub src", 1'b1, near(int'(20800.0 / per), tg[2]))
            `CHK("tb src", 1'b1, near(int'(2600.0 / per), tg[3]))
            `CHK("lcd src", 1'b1, near(lcd_on ? int'(20800.0 / per) : 0, tg[4])
                && tg[4] == tg[5])
        end
        $display("sub clock test done");
        sys_clk_select = SEL_SUB_CLOCK;
        rc_freq_select = 3'h0;
        // both high groups: the selected one lives only by its own enable bit
        for (int f = 0; f < 4; f++) begin
            high_osc_select = f[1];
            fast_crystal_on = f[0] & f[1];
            rc_osc_on = f[0] & !f[1];
            window(100);
            `CHK("slow mode", MODE_SLOW, power_mode)
            `CHK("high keep", f[0], f[1] ? fast_crystal_en : fast_rc_en)
            `CHK("high run", f[0], tg[1] != 0)
        end
        $display("slow mode test done");
        print_verdict();
    end
endmodule
